/* File: core/mul_unit_defines.svh */
// Constants for the integer multiply unit: widths, latency, pair reset value.
// Assumes inclusion by name from the core/ directory.
`ifndef MUL_UNIT_DEFINES_SVH
`define MUL_UNIT_DEFINES_SVH

`define MUL_WORD_W      32
`define MUL_DPATH_W     64
`define MUL_PROD_W      64
`define MUL_IDX_W       5
`define MUL_OP_W        4
`define MUL_LAT_NS      40
`define MUL_CLK_NS      10
`define MUL_LAT_CYC     (`MUL_LAT_NS / `MUL_CLK_NS)
`define MUL_CNT_W       3
`define MUL_RST_PAIR    32'h00000000

`endif

/* File: core/mul_unit_pkg.sv */
// Types shared by both ends of the multiply unit link.
// Assumes mul_unit_defines.svh is on the include path.
`include "mul_unit_defines.svh"

package mul_unit_pkg;

    typedef enum logic [`MUL_OP_W-1:0] {
        OP_NONE                   = 4'h0,
        OP_WRITE_TOP_PRODUCT      = 4'h1,
        OP_WRITE_BOTTOM_PRODUCT   = 4'h2,
        OP_SIGNED_PRODUCT_TO_PAIR = 4'h3,
        OP_UNSIGNED_PRODUCT_TO_PAIR = 4'h4,
        OP_LEGACY_PRODUCT_LOW     = 4'h5,
        OP_PRODUCT_LOW_SIGNED     = 4'h6,
        OP_PRODUCT_HIGH_SIGNED    = 4'h7,
        OP_PRODUCT_LOW_UNSIGNED   = 4'h8,
        OP_PRODUCT_HIGH_UNSIGNED  = 4'h9,
        OP_READ_TOP_PRODUCT       = 4'hA,
        OP_READ_BOTTOM_PRODUCT    = 4'hB
    } mul_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } mul_state_t;

endpackage : mul_unit_pkg

/* File: core/mul_link_if.sv */
// Link between the issue pipeline and the multiply unit.
// Single clock domain; both ends run on the core clock.
`include "mul_unit_defines.svh"

interface mul_link_if;
    logic                       req_valid;
    logic                       req_ready;
    mul_unit_pkg::mul_op_t      req_op;
    logic [`MUL_DPATH_W-1:0]    req_a;
    logic [`MUL_DPATH_W-1:0]    req_b;
    logic [`MUL_IDX_W-1:0]      req_dest;
    logic                       res_valid;
    logic [`MUL_WORD_W-1:0]     res_data;
    logic [`MUL_IDX_W-1:0]      res_dest;
    logic                       busy;
    logic [`MUL_IDX_W-1:0]      busy_dest;
    logic                       busy_pair;
    logic                       illegal_op;

    modport unit
    (
        input  req_valid, req_op, req_a, req_b, req_dest,
        output req_ready, res_valid, res_data, res_dest, busy, busy_dest, busy_pair,
               illegal_op
    );

    modport pipe
    (
        output req_valid, req_op, req_a, req_b, req_dest,
        input  req_ready, res_valid, res_data, res_dest, busy, busy_dest, busy_pair,
               illegal_op
    );
endinterface : mul_link_if

/* File: core/integer_multiply_unit.sv */
// Integer multiply unit: product register pair, pair moves and register-result
// multiplies with a four-cycle latency (one cycle for a fused high half) and an issue interlock.
// Assumes the pipe end holds requests stable while req_ready is low.
`include "mul_unit_defines.svh"

// Functional notes
// - Bottom move loads operand A fully
// - Software reads pair before overwriting halves
// - Pair write may follow read immediately
// - Release 6 lacks pair moves
// - Legacy signed multiply writes low word
// - Legacy multiply leaves pair arbitrary
// - No overflow exception ever raised
// - Reads of pending destination stall
// - Later instructions may overlap multiply
// - Shorter operand goes in operand B
// - Software checks overflow explicitly
// - Signed low word to register
// - Signed high word to register
// - Unsigned low word to register
// - Unsigned high word to register
// - Upper operand bits 32-63 ignored
// - Release 6 has no pair registers
// - Low then high may fuse
// - Release 6 provides all four multiplies
// - Signed product split into pair
// - Top move loads operand A fully
// - Unsigned product split into pair
// - Pair reads stall while multiply pending
module integer_multiply_unit #(
    parameter bit RELEASE6 = 1'b0
)
(
    input  wire logic   SYS_CLK,
    input  wire logic   RESET,
    mul_link_if.unit    LINK
);

    logic                       busy_ff,      nxt_busy;
    logic [`MUL_CNT_W-1:0]      cnt_ff,       nxt_cnt;
    mul_unit_pkg::mul_op_t      op_ff,        nxt_op;
    logic [`MUL_PROD_W-1:0]     prod_ff,      nxt_prod;
    logic [`MUL_IDX_W-1:0]      dest_ff,      nxt_dest;
    logic [`MUL_WORD_W-1:0]     top_ff,       nxt_top;
    logic [`MUL_WORD_W-1:0]     bottom_ff,    nxt_bottom;
    logic                       rvalid_ff,    nxt_rvalid;
    logic [`MUL_WORD_W-1:0]     rdata_ff,     nxt_rdata;
    logic [`MUL_IDX_W-1:0]      rdest_ff,     nxt_rdest;
    logic                       ready_ff,     nxt_ready;
    logic                       illegal_ff,   nxt_illegal;
    logic                       pair_ff,      nxt_pair;
    logic                       fuse_ok_ff,   nxt_fuse_ok;
    mul_unit_pkg::mul_op_t      fuse_op_ff,   nxt_fuse_op;
    logic [`MUL_WORD_W-1:0]     fuse_a_ff,    nxt_fuse_a;
    logic [`MUL_WORD_W-1:0]     fuse_b_ff,    nxt_fuse_b;

    logic [`MUL_WORD_W-1:0]     a_w;
    logic [`MUL_WORD_W-1:0]     b_w;
    logic [`MUL_PROD_W-1:0]     prod_s;
    logic [`MUL_PROD_W-1:0]     prod_u;
    logic                       is_pair_op;
    logic                       is_r6_op;
    logic                       is_mul;
    logic                       legal;
    logic                       done;
    logic                       fuse_hit;

    assign a_w = LINK.req_a[`MUL_WORD_W-1:0];
    assign b_w = LINK.req_b[`MUL_WORD_W-1:0];
    assign prod_s = 64'($signed(a_w) * $signed(b_w));
    assign prod_u = 64'(a_w * b_w);

    always_comb
    begin
        is_pair_op = 1'b0;
        is_r6_op   = 1'b0;
        is_mul     = 1'b0;
        unique case (LINK.req_op)
            mul_unit_pkg::OP_WRITE_TOP_PRODUCT,
            mul_unit_pkg::OP_WRITE_BOTTOM_PRODUCT,
            mul_unit_pkg::OP_READ_TOP_PRODUCT,
            mul_unit_pkg::OP_READ_BOTTOM_PRODUCT:
                is_pair_op = 1'b1;
            mul_unit_pkg::OP_SIGNED_PRODUCT_TO_PAIR,
            mul_unit_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR,
            mul_unit_pkg::OP_LEGACY_PRODUCT_LOW:
            begin
                is_pair_op = 1'b1;
                is_mul     = 1'b1;
            end
            mul_unit_pkg::OP_PRODUCT_LOW_SIGNED,
            mul_unit_pkg::OP_PRODUCT_HIGH_SIGNED,
            mul_unit_pkg::OP_PRODUCT_LOW_UNSIGNED,
            mul_unit_pkg::OP_PRODUCT_HIGH_UNSIGNED:
            begin
                is_r6_op = 1'b1;
                is_mul   = 1'b1;
            end
            default:
                is_pair_op = 1'b0;
        endcase
    end

    assign legal = RELEASE6 ? is_r6_op : is_pair_op;
    // High half reuses matching low product
    assign fuse_hit = fuse_ok_ff && (a_w == fuse_a_ff) && (b_w == fuse_b_ff)
                      && (((LINK.req_op == mul_unit_pkg::OP_PRODUCT_HIGH_SIGNED)
                           && (fuse_op_ff == mul_unit_pkg::OP_PRODUCT_LOW_SIGNED))
                       || ((LINK.req_op == mul_unit_pkg::OP_PRODUCT_HIGH_UNSIGNED)
                           && (fuse_op_ff == mul_unit_pkg::OP_PRODUCT_LOW_UNSIGNED)));
    assign done = busy_ff && (cnt_ff == '0);

    always_comb
    begin
        nxt_busy      = busy_ff;
        nxt_cnt       = cnt_ff;
        nxt_op        = op_ff;
        nxt_prod      = prod_ff;
        nxt_dest      = dest_ff;
        nxt_top       = top_ff;
        nxt_bottom    = bottom_ff;
        nxt_rvalid    = 1'b0;
        nxt_rdata     = rdata_ff;
        nxt_rdest     = rdest_ff;
        nxt_illegal   = 1'b0;
        nxt_pair      = pair_ff;
        nxt_fuse_ok   = fuse_ok_ff;
        nxt_fuse_op   = fuse_op_ff;
        nxt_fuse_a    = fuse_a_ff;
        nxt_fuse_b    = fuse_b_ff;
        if (busy_ff)
            nxt_cnt = cnt_ff - `MUL_CNT_W'(1);

        if (done)
        begin
            nxt_busy = 1'b0;
            nxt_pair = 1'b0;
            unique case (op_ff)
                mul_unit_pkg::OP_SIGNED_PRODUCT_TO_PAIR,
                mul_unit_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR:
                begin
                    nxt_bottom = prod_ff[`MUL_WORD_W-1:0];
                    nxt_top    = prod_ff[`MUL_PROD_W-1:`MUL_WORD_W];
                end
                // Low word out, pair left as is
                mul_unit_pkg::OP_LEGACY_PRODUCT_LOW,
                mul_unit_pkg::OP_PRODUCT_LOW_SIGNED,
                mul_unit_pkg::OP_PRODUCT_LOW_UNSIGNED:
                begin
                    nxt_rvalid = 1'b1;
                    nxt_rdata  = prod_ff[`MUL_WORD_W-1:0];
                    nxt_rdest  = dest_ff;
                end
                default:
                begin
                    nxt_rvalid = 1'b1;
                    nxt_rdata  = prod_ff[`MUL_PROD_W-1:`MUL_WORD_W];
                    nxt_rdest  = dest_ff;
                end
            endcase
        end

        if (LINK.req_valid && ready_ff)
        begin
            if (!legal)
                nxt_illegal = 1'b1;
            else if (is_mul)
            begin
                nxt_op   = LINK.req_op;
                nxt_dest = LINK.req_dest;
                nxt_busy = 1'b1;
                nxt_pair = is_pair_op && (LINK.req_op != mul_unit_pkg::OP_LEGACY_PRODUCT_LOW);
                nxt_cnt  = fuse_hit ? '0 : `MUL_CNT_W'(`MUL_LAT_CYC - 1);
                nxt_prod = (LINK.req_op inside {mul_unit_pkg::OP_UNSIGNED_PRODUCT_TO_PAIR,
                                                mul_unit_pkg::OP_PRODUCT_LOW_UNSIGNED,
                                                mul_unit_pkg::OP_PRODUCT_HIGH_UNSIGNED})
                           ? prod_u : prod_s;
                nxt_fuse_ok = is_r6_op;
                nxt_fuse_op = LINK.req_op;
                nxt_fuse_a  = a_w;
                nxt_fuse_b  = b_w;
            end
            else
            begin
                // Moves act at once, no gap needed
                unique case (LINK.req_op)
                    mul_unit_pkg::OP_WRITE_TOP_PRODUCT:
                        nxt_top = a_w;
                    mul_unit_pkg::OP_WRITE_BOTTOM_PRODUCT:
                        nxt_bottom = a_w;
                    mul_unit_pkg::OP_READ_TOP_PRODUCT:
                    begin
                        nxt_rvalid = 1'b1;
                        nxt_rdata  = top_ff;
                        nxt_rdest  = LINK.req_dest;
                    end
                    default:
                    begin
                        nxt_rvalid = 1'b1;
                        nxt_rdata  = bottom_ff;
                        nxt_rdest  = LINK.req_dest;
                    end
                endcase
            end
        end
        nxt_ready = !nxt_busy;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            busy_ff      <= 1'b0;
            cnt_ff       <= '0;
            op_ff        <= mul_unit_pkg::OP_NONE;
            prod_ff      <= '0;
            dest_ff      <= '0;
            top_ff       <= `MUL_RST_PAIR;
            bottom_ff    <= `MUL_RST_PAIR;
            rvalid_ff    <= 1'b0;
            rdata_ff     <= '0;
            rdest_ff     <= '0;
            ready_ff     <= 1'b1;
            illegal_ff   <= 1'b0;
            pair_ff      <= 1'b0;
            fuse_ok_ff   <= 1'b0;
            fuse_op_ff   <= mul_unit_pkg::OP_NONE;
            fuse_a_ff    <= '0;
            fuse_b_ff    <= '0;
        end
        else
        begin
            busy_ff      <= nxt_busy;
            cnt_ff       <= nxt_cnt;
            op_ff        <= nxt_op;
            prod_ff      <= nxt_prod;
            dest_ff      <= nxt_dest;
            top_ff       <= nxt_top;
            bottom_ff    <= nxt_bottom;
            rvalid_ff    <= nxt_rvalid;
            rdata_ff     <= nxt_rdata;
            rdest_ff     <= nxt_rdest;
            ready_ff     <= nxt_ready;
            illegal_ff   <= nxt_illegal;
            pair_ff      <= nxt_pair;
            fuse_ok_ff   <= nxt_fuse_ok;
            fuse_op_ff   <= nxt_fuse_op;
            fuse_a_ff    <= nxt_fuse_a;
            fuse_b_ff    <= nxt_fuse_b;
        end
    end

    assign LINK.req_ready  = ready_ff;
    assign LINK.res_valid  = rvalid_ff;
    assign LINK.res_data   = rdata_ff;
    assign LINK.res_dest   = rdest_ff;
    assign LINK.busy       = busy_ff;
    assign LINK.busy_dest  = dest_ff;
    assign LINK.busy_pair  = pair_ff;
    assign LINK.illegal_op = illegal_ff;

endmodule : integer_multiply_unit

/* File: core/multiply_issue_port.sv */
// Pipe end of the multiply link: passes each request straight through to the unit,
// returns results to the register file and stalls dependent reads.
// Assumes the user holds USER_VALID and its fields until USER_READY.
`include "mul_unit_defines.svh"

module multiply_issue_port
(
    input  wire logic                       SYS_CLK,
    input  wire logic                       RESET,
    mul_link_if.pipe                        LINK,
    input  wire logic                       USER_VALID,
    input  wire mul_unit_pkg::mul_op_t      USER_OP,
    input  wire logic [`MUL_DPATH_W-1:0]    USER_A,
    input  wire logic [`MUL_DPATH_W-1:0]    USER_B,
    input  wire logic [`MUL_IDX_W-1:0]      USER_DEST,
    input  wire logic                       USER_RD_VALID,
    input  wire logic [`MUL_IDX_W-1:0]      USER_RD_INDEX,
    output logic                            USER_READY,
    output logic                            USER_RD_STALL,
    output logic                            WB_VALID,
    output logic [`MUL_WORD_W-1:0]          WB_DATA,
    output logic [`MUL_IDX_W-1:0]           WB_INDEX,
    output logic                            ILLEGAL
);

    logic   stall_ff,  nxt_stall;
    logic   wbv_ff,    nxt_wbv;
    logic [`MUL_WORD_W-1:0] wbd_ff, nxt_wbd;
    logic [`MUL_IDX_W-1:0]  wbi_ff, nxt_wbi;
    logic   ill_ff,    nxt_ill;

    // Operands passed in the order given
    assign LINK.req_valid = USER_VALID;
    assign LINK.req_op    = USER_OP;
    assign LINK.req_a     = USER_A;
    assign LINK.req_b     = USER_B;
    assign LINK.req_dest  = USER_DEST;

    always_comb
    begin
        nxt_stall = USER_RD_VALID && LINK.busy && !LINK.busy_pair
                    && (USER_RD_INDEX == LINK.busy_dest);
        nxt_wbv   = LINK.res_valid;
        nxt_wbd   = LINK.res_data;
        nxt_wbi   = LINK.res_dest;
        nxt_ill   = LINK.illegal_op;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            stall_ff <= 1'b0;
            wbv_ff   <= 1'b0;
            wbd_ff   <= '0;
            wbi_ff   <= '0;
            ill_ff   <= 1'b0;
        end
        else
        begin
            stall_ff <= nxt_stall;
            wbv_ff   <= nxt_wbv;
            wbd_ff   <= nxt_wbd;
            wbi_ff   <= nxt_wbi;
            ill_ff   <= nxt_ill;
        end
    end

    // Unit's ready flop passed through so a held multiply request is taken once
    assign USER_READY    = LINK.req_ready;
    assign USER_RD_STALL = stall_ff;
    assign WB_VALID      = wbv_ff;
    assign WB_DATA       = wbd_ff;
    assign WB_INDEX      = wbi_ff;
    assign ILLEGAL       = ill_ff;

endmodule : multiply_issue_port

/* File: verif/mul_link_monitor.sv */
// Checker for the link of the legacy unit.
// Assumes one clock domain and a synchronous active-high reset.
`include "mul_unit_defines.svh"

module mul_link_monitor
(
    input wire logic                    SYS_CLK,
    input wire logic                    RESET,
    input wire logic                    req_valid,
    input wire logic                    req_ready,
    input wire mul_unit_pkg::mul_op_t   req_op,
    input wire logic [`MUL_DPATH_W-1:0] req_a,
    input wire logic [`MUL_DPATH_W-1:0] req_b,
    input wire logic [`MUL_IDX_W-1:0]   req_dest,
    input wire logic                    res_valid,
    input wire logic [`MUL_WORD_W-1:0]  res_data,
    input wire logic [`MUL_IDX_W-1:0]   res_dest,
    input wire logic                    busy,
    input wire logic [`MUL_IDX_W-1:0]   busy_dest,
    input wire logic                    busy_pair,
    input wire logic                    illegal_op
);
    timeunit 1ns;
    timeprecision 1ps;

    logic                   take;
    logic                   take_low;
    logic                   take_mul;
    logic                   take_pair;
    logic                   take_read;
    logic                   take_move;
    logic [`MUL_WORD_W-1:0] low_word;

    assign take      = req_valid && req_ready;
    assign take_low  = take && req_op == mul_unit_pkg::OP_LEGACY_PRODUCT_LOW;
    assign take_pair = take && req_op inside {4'h3, 4'h4};
    assign take_mul  = take_low || take_pair;
    assign take_read = take && req_op inside {4'hA, 4'hB};
    assign take_move = take && req_op inside {4'h1, 4'h2};
    // Low word is the same for signed and unsigned
    assign low_word  = req_a[31:0] * req_b[31:0];

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);

    AST_BUSY_SPAN: assert property (take_mul |=> busy [*4] ##1 !busy)
        else $error("multiply busy span wrong");
    AST_NO_READY_BUSY: assert property (busy |-> !req_ready)
        else $error("request accepted while busy");
    AST_LOW_RESULT: assert property (take_low |-> ##5 res_valid
        && res_dest == $past(req_dest, 5) && res_data == $past(low_word, 5))
        else $error("legacy low result wrong");
    AST_BUSY_DEST: assert property (take_mul |=> busy_dest == $past(req_dest))
        else $error("busy destination wrong");
    AST_PAIR_FLAG: assert property (take_mul |=> busy_pair == $past(take_pair))
        else $error("pair busy flag wrong");
    AST_READ_ANSWER: assert property (take_read |=> res_valid && !illegal_op)
        else $error("pair read not answered");
    AST_MOVE_QUIET: assert property (take_move |=> !res_valid && !illegal_op)
        else $error("pair move answered");
    AST_NO_FAULT: assert property (take && req_op inside {[4'h1:4'h5], 4'hA, 4'hB}
        |=> !illegal_op)
        else $error("legal request flagged");

    COV_LOW: cover property (take_low);
    COV_PAIR_READ: cover property (take_pair ##[1:8] take_read);
    COV_READ_MOVE: cover property (take_read ##1 take_move);
endmodule : mul_link_monitor

/* File: verif/testbench.sv */
// Bench joining a legacy unit and a Release 6 unit to their issue ports.
// Assumes the core/ files compile first and core/ is on the include path.
`include "mul_unit_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                    sys_clk;
    logic                    reset;
    logic                    uv [2];
    mul_unit_pkg::mul_op_t   uop [2];
    logic [`MUL_DPATH_W-1:0] ua [2];
    logic [`MUL_DPATH_W-1:0] ub [2];
    logic [`MUL_IDX_W-1:0]   ud [2];
    logic                    rdv [2];
    logic [`MUL_IDX_W-1:0]   rdi [2];
    logic                    lrdy [2];
    logic                    urdy [2];
    logic                    stall [2];
    logic                    wbv [2];
    logic [`MUL_WORD_W-1:0]  wbd [2];
    logic [`MUL_IDX_W-1:0]   wbi [2];
    logic                    ill [2];
    logic                    seen_stall;
    logic [63:0]             a_op;
    logic [63:0]             b_op;
    logic [63:0]             ps;
    logic [63:0]             pu;
    int                      bad_count;
    int                      checked;

    mul_link_if lk [2] ();

    // End 0 is legacy, end 1 is Release 6
    for (genvar g = 0; g < 2; g++)
    begin : g_end
        integer_multiply_unit #(.RELEASE6(g == 1)) u_integer_multiply_unit
        (
            .SYS_CLK (sys_clk),
            .RESET   (reset),
            .LINK    (lk[g])
        );
        multiply_issue_port u_multiply_issue_port
        (
            .SYS_CLK       (sys_clk),
            .RESET         (reset),
            .LINK          (lk[g]),
            .USER_VALID    (uv[g]),
            .USER_OP       (uop[g]),
            .USER_A        (ua[g]),
            .USER_B        (ub[g]),
            .USER_DEST     (ud[g]),
            .USER_RD_VALID (rdv[g]),
            .USER_RD_INDEX (rdi[g]),
            .USER_READY    (urdy[g]),
            .USER_RD_STALL (stall[g]),
            .WB_VALID      (wbv[g]),
            .WB_DATA       (wbd[g]),
            .WB_INDEX      (wbi[g]),
            .ILLEGAL       (ill[g])
        );
        assign lrdy[g] = lk[g].req_ready;
    end

    mul_link_monitor u_mul_link_monitor
    (
        .SYS_CLK    (sys_clk),
        .RESET      (reset),
        .req_valid  (lk[0].req_valid),
        .req_ready  (lk[0].req_ready),
        .req_op     (lk[0].req_op),
        .req_a      (lk[0].req_a),
        .req_b      (lk[0].req_b),
        .req_dest   (lk[0].req_dest),
        .res_valid  (lk[0].res_valid),
        .res_data   (lk[0].res_data),
        .res_dest   (lk[0].res_dest),
        .busy       (lk[0].busy),
        .busy_dest  (lk[0].busy_dest),
        .busy_pair  (lk[0].busy_pair),
        .illegal_op (lk[0].illegal_op)
    );

    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Hold keeps valid up so a following request goes back to back
    task automatic issue(input int i, input int op, input logic [63:0] a,
                         input logic [63:0] b, input logic [4:0] d, input bit hold);
        int n;
        n = 0;
        uv[i] <= 1'h1;
        uop[i] <= mul_unit_pkg::mul_op_t'(op[3:0]);
        ua[i] <= a;
        ub[i] <= b;
        ud[i] <= d;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (lrdy[i] !== 1'h1 && n < 40);
        chk("accept", 32'h1, {31'h0, lrdy[i]});
        if (!hold)
            uv[i] <= 1'h0;
    endtask : issue

    task automatic wait_wb(input int i, input logic [31:0] exp, input logic [4:0] d);
        int n;
        n = 0;
        seen_stall = 1'h0;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (stall[i] === 1'h1)
                seen_stall = 1'h1;
        end
        while (wbv[i] !== 1'h1 && n < 40);
        chk("wb valid", 32'h1, {31'h0, wbv[i]});
        chk("wb data", exp, wbd[i]);
        chk("wb index", {27'h0, d}, {27'h0, wbi[i]});
    endtask : wait_wb

    task automatic t_moves();
        issue(0, 1, 64'hFFFF0000_13579BDF, 64'h0, 5'h0, 1'h1);
        issue(0, 2, 64'h0000FFFF_2468ACE0, 64'h0, 5'h0, 1'h1);
        issue(0, 11, 64'h0, 64'h0, 5'h2, 1'h1);
        issue(0, 1, 64'hFFFFFFFF_89ABCDEF, 64'h0, 5'h0, 1'h0);
        wait_wb(0, 32'h2468ACE0, 5'h2);
        issue(0, 10, 64'h0, 64'h0, 5'h3, 1'h0);
        wait_wb(0, 32'h89ABCDEF, 5'h3);
    endtask : t_moves

    task automatic t_pair();
        for (int s = 0; s < 2; s++)
        begin
            issue(0, 3 + s, a_op, b_op, 5'h0, 1'h1);
            issue(0, 11, 64'h0, 64'h0, 5'h9, 1'h0);
            wait_wb(0, s ? pu[31:0] : ps[31:0], 5'h9);
            issue(0, 10, 64'h0, 64'h0, 5'hA, 1'h0);
            wait_wb(0, s ? pu[63:32] : ps[63:32], 5'hA);
        end
    endtask : t_pair

    task automatic t_legacy_mul();
        issue(0, 5, a_op, b_op, 5'h7, 1'h0);
        rdv[0] <= 1'h1;
        rdi[0] <= 5'h7;
        repeat (2) @(posedge sys_clk);
        chk("user ready", 32'h0, {31'h0, urdy[0]});
        wait_wb(0, ps[31:0], 5'h7);
        chk("stall", 32'h1, {31'h0, seen_stall});
        repeat (2) @(posedge sys_clk);
        chk("stall clear", 32'h0, {31'h0, stall[0]});
        rdv[0] <= 1'h0;
        issue(0, 5, b_op, b_op, 5'h3, 1'h1);
        issue(0, 5, a_op, a_op, 5'h4, 1'h0);
        wait_wb(0, 32'(b_op[31:0] * b_op[31:0]), 5'h3);
        wait_wb(0, 32'(a_op[31:0] * a_op[31:0]), 5'h4);
    endtask : t_legacy_mul

    task automatic t_r6_ops();
        logic [63:0] e;
        for (int k = 0; k < 4; k++)
        begin
            e = (k < 2) ? ps : pu;
            issue(1, 6 + k, a_op, b_op, 5'(k + 1), 1'h0);
            wait_wb(1, k[0] ? e[63:32] : e[31:0], 5'(k + 1));
        end
    endtask : t_r6_ops

    task automatic t_illegal();
        int n;
        int e;
        // Release 6 ops to the legacy end, all others to the Release 6 end
        for (int k = 0; k < 12; k++)
        begin
            e = (k > 5 && k < 10) ? 0 : 1;
            issue(e, k, a_op, b_op, 5'h1, 1'h0);
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
            end
            while (ill[e] !== 1'h1 && n < 10);
            chk("illegal", 32'h1, {31'h0, ill[e]});
        end
    endtask : t_illegal

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #100000;
        bad_count++;
        end_of_test();
    end

    initial
    begin
        reset = 1'h1;
        bad_count = 0;
        checked = 0;
        for (int i = 0; i < 2; i++)
        begin
            uv[i] = 1'h0;
            uop[i] = mul_unit_pkg::OP_NONE;
            ua[i] = 64'h0;
            ub[i] = 64'h0;
            ud[i] = 5'h0;
            rdv[i] = 1'h0;
            rdi[i] = 5'h0;
        end
        // Upper halves carry junk that must not matter
        a_op = 64'hA5A5A5A5_FFFFFFFD;
        b_op = 64'h5A5A5A5A_7FFFFFF1;
        ps = {{32{a_op[31]}}, a_op[31:0]} * {{32{b_op[31]}}, b_op[31:0]};
        pu = {32'h0, a_op[31:0]} * {32'h0, b_op[31:0]};
        repeat (8) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        t_moves();
        t_pair();
        t_legacy_mul();
        t_r6_ops();
        t_illegal();
        end_of_test();
    end
endmodule : testbench
